// >>> hdl/eac_map.svh
// Register indices, field positions, reset values and fixed codes of the event compare block.
`ifndef EAC_MAP_SVH
`define EAC_MAP_SVH
// Register indices; the byte address on the bus is four times the index.
`define EAC_IDX_CMP0_CTRL  16'h1F88
`define EAC_IDX_CMP0_TIME  16'h1F8A
`define EAC_IDX_CMP1_CTRL  16'h1F8C
`define EAC_IDX_CMP1_TIME  16'h1F8E
`define EAC_IDX_CH_CTRL    16'h1F60
`define EAC_IDX_CH_TIME    16'h1F62
`define EAC_IDX_CH_STRIDE  16'h0004
`define EAC_IDX_EN_MAIN    16'h1FA0
`define EAC_IDX_PEND_MAIN  16'h1FA2
`define EAC_IDX_EN_EXTRA   16'h1FA4
`define EAC_IDX_PEND_EXTRA 16'h1FA6
`define EAC_IDX_PRIO_VEC   16'h1FA8
`define EAC_IDX_CLR_MAIN   16'h1FB0
`define EAC_IDX_CLR_EXTRA  16'h1FB2
`define EAC_IDX_CORE_EN    16'h0008
// Field positions inside a control byte and the sharing bit of the upper byte.
`define EAC_F_TB           7
`define EAC_F_CE           6
`define EAC_F_RM           8
// Compare action encodings.
`define EAC_ACT_NONE       2'h0
`define EAC_ACT_CLEAR      2'h1
`define EAC_ACT_SET        2'h2
`define EAC_ACT_TOGGLE     2'h3
// Reset values.
`define EAC_RST_CTRL       8'h00
`define EAC_RST_TIME       16'h0000
`define EAC_RST_HI_SHARE   16'hFE00
`define EAC_RST_HI_PLAIN   16'h0000
`endif

// >>> hdl/eac_pkg.sv
// Types shared by the event compare block and its users.
package eac_pkg;
   // Layout of one channel control byte.
   typedef struct packed {
      logic       timebase_select;
      logic       compare_enable;
      logic [1:0] compare_action_select;
      logic       continuous_match_mode;
      logic       conversion_trigger;
      logic       which_timer_clear_select;
      logic       timer_clear_enable;
   } eac_ctrl_t;
   // One-cycle trigger pulses sent to the converter and the two timers.
   typedef struct packed {
      logic adc_start;
      logic timer1_clear;
      logic timer2_clear;
   } eac_trig_t;
endpackage

// >>> hdl/eac_top.sv
// Event compare and capture channels with the multiplexed event interrupt logic.
`timescale 1ns/1ps
`include "eac_map.svh"

module eac_top #(
   parameter int TW = 16                       // Timer and event time width.
) (
   input  wire logic                clk_i,       // Core clock.
   input  wire logic                rst_i,       // Synchronous reset, active high.
   input  wire logic                cyc_i,       // Wishbone cycle.
   input  wire logic                stb_i,       // Wishbone strobe.
   input  wire logic                we_i,        // Wishbone write enable.
   input  wire logic [15:0]         adr_i,       // Wishbone byte address.
   input  wire logic [3:0]          sel_i,       // Wishbone byte selects.
   input  wire logic [31:0]         dat_i,       // Wishbone write data.
   output logic      [31:0]         dat_o,       // Wishbone read data.
   output logic                     ack_o,       // Wishbone acknowledge.
   input  wire logic [TW-1:0]       timer1_i,    // Timer 1 count.
   input  wire logic [TW-1:0]       timer2_i,    // Timer 2 count.
   input  wire logic                timer1_ovf_i, // Timer 1 overflow pulse.
   input  wire logic                timer2_ovf_i, // Timer 2 overflow pulse.
   input  wire logic [9:0]          chan_pin_i,  // Channel input pins.
   output logic      [9:0]          chan_pin_o,  // Channel output pins.
   output logic      [1:0]          cmp_pin_o,   // Compare-only unit output pins.
   output logic      [3:0]          chan_irq_o,  // Event pulses of channels 0 to 3.
   output eac_pkg::eac_trig_t       trig_o,      // Converter and timer clear pulses.
   output logic                     irq_o        // Multiplexed event interrupt.
);
   import eac_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   ////////////////////////////////////////////////////////////////////////////
   localparam int NCH = 10;                    // Capture and compare channels.
   localparam int NU  = 12;                    // Channels plus two compare-only units.
   localparam int NS  = 20;                    // Multiplexed interrupt sources.

   logic [7:0]    ctrl_reg  [NU];              // Control bytes, units 10 and 11 compare-only.
   logic [TW-1:0] time_reg  [NU];              // Event time registers.
   logic [1:0]    share_reg;                   // Pin sharing bits of channels 1 and 3.
   logic [NU-1:0] armed_reg;                   // Unit may still act on a match.
   logic [NU-1:0] eq_prev_reg;                 // Match condition seen last cycle.
   logic [NCH-1:0] full_reg;                   // Captured value not yet read.
   logic [9:0]    pin_reg;                     // Channel pin drivers.
   logic [1:0]    cmp_pin_reg;                 // Compare-only pin drivers.
   logic [NCH-1:0] sync1_reg;                  // First synchroniser stage.
   logic [NCH-1:0] sync2_reg;                  // Second synchroniser stage.
   logic [NCH-1:0] sync3_reg;                  // Edge detect history.
   logic [NS-1:0] pend_reg;                    // Flags: main in 19:4, extra in 3:0.
   logic [NS-1:0] en_reg;                      // Source enables, same layout.
   logic          core_en_reg;                 // Core level enable of the interrupt.
   logic          ack_reg;                     // Registered acknowledge.
   logic [31:0]   dat_reg;                     // Registered read data.
   eac_trig_t     trig_reg;                    // Registered trigger pulses.
   logic [3:0]    chan_irq_reg;                // Registered channel event pulses.

   logic          req;                         // New bus request this cycle.
   logic          wr;                          // New write request.
   logic          rd;                          // New read request.
   logic [NU-1:0] cmp_ev;                      // Compare events.
   logic [NU-1:0] cap_ev;                      // Capture events.
   logic [NCH-1:0] ovr_ev;                     // Capture overruns.
   logic [NU-1:0] eq_now;                      // Match condition this cycle.
   logic [NS-1:0] src;                         // Sources raising a flag.
   logic [NS-1:0] active;                      // Flagged and enabled sources.
   logic [4:0]    vec_code;                    // Priority vector value.
   logic [NS-1:0] clr;                         // Flags cleared this cycle.
   logic [31:0]   rdata;                       // Read data mux.
   logic [NU-1:0] wr_ctrl;                     // Write strobes of control bytes.
   logic [NU-1:0] wr_time;                     // Write strobes of event times.
   logic [NCH-1:0] rd_time;                    // Read strobes of channel times.
   logic          t1_clr;                      // Timer 1 clear request.
   logic          t2_clr;                      // Timer 2 clear request.
   logic          adc_go;                      // Converter start request.

   ////////////////////////////////////////////////////////////////////////////
   // Functions.
   ////////////////////////////////////////////////////////////////////////////
   // Byte address of a register index.
   function automatic logic [15:0] reg_addr(input logic [15:0] idx);
      return {idx[13:0], 2'h0};
   endfunction

   // Merge the selected byte lanes of write data into a 16-bit register.
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // Pin level after a compare action.
   function automatic logic pin_act(input logic p, input logic [1:0] a);
      logic r;
      r = p;
      case (a)
         `EAC_ACT_CLEAR:  r = 1'b0;
         `EAC_ACT_SET:    r = 1'b1;
         `EAC_ACT_TOGGLE: r = ~p;
         default:         r = p;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode and read mux.
   ////////////////////////////////////////////////////////////////////////////
   assign req = cyc_i & stb_i & ~ack_reg;
   assign wr  = req & we_i;
   assign rd  = req & ~we_i;

   // Decode the address into strobes and select read data; unmapped reads give zero.
   always_comb
   begin
      rdata   = 32'h0000_0000;
      wr_ctrl = '0;
      wr_time = '0;
      rd_time = '0;
      if (adr_i == reg_addr(`EAC_IDX_CMP0_CTRL))
      begin
         rdata[7:0] = ctrl_reg[10];
         wr_ctrl[10] = wr;
      end
      else if (adr_i == reg_addr(`EAC_IDX_CMP0_TIME))
      begin
         rdata[TW-1:0] = time_reg[10];
         wr_time[10] = wr;
      end
      else if (adr_i == reg_addr(`EAC_IDX_CMP1_CTRL))
      begin
         rdata[7:0] = ctrl_reg[11];
         wr_ctrl[11] = wr;
      end
      else if (adr_i == reg_addr(`EAC_IDX_CMP1_TIME))
      begin
         rdata[TW-1:0] = time_reg[11];
         wr_time[11] = wr;
      end
      else if (adr_i == reg_addr(`EAC_IDX_EN_MAIN))
         rdata[15:0] = en_reg[19:4];
      else if (adr_i == reg_addr(`EAC_IDX_PEND_MAIN))
         rdata[15:0] = pend_reg[19:4];
      else if (adr_i == reg_addr(`EAC_IDX_EN_EXTRA))
         rdata[3:0] = en_reg[3:0];
      else if (adr_i == reg_addr(`EAC_IDX_PEND_EXTRA))
         rdata[3:0] = pend_reg[3:0];
      else if (adr_i == reg_addr(`EAC_IDX_PRIO_VEC))
         rdata[4:0] = vec_code;
      else if (adr_i == reg_addr(`EAC_IDX_CORE_EN))
         rdata[0] = core_en_reg;
      else
      begin
         // Channel registers share one stride; others read as zero.
         for (int i = 0; i < NCH; i++)
         begin
            if (adr_i == reg_addr(`EAC_IDX_CH_CTRL + 16'(i * 4)))
            begin
               rdata[15:0] = {((i == 1) || (i == 3)) ? `EAC_RST_HI_SHARE : `EAC_RST_HI_PLAIN}
                             | {8'h00, ctrl_reg[i]};
               if (i == 1)
                  rdata[`EAC_F_RM] = share_reg[0];
               if (i == 3)
                  rdata[`EAC_F_RM] = share_reg[1];
               wr_ctrl[i] = wr;
            end
            else if (adr_i == reg_addr(`EAC_IDX_CH_TIME + 16'(i * 4)))
            begin
               rdata[TW-1:0] = time_reg[i];
               wr_time[i]    = wr;
               rd_time[i]    = rd;
            end
         end
      end
   end

   // Acknowledge one cycle after the request, then drop it for one cycle.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= req;
         if (rd)
            dat_reg <= rdata;
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = dat_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and per-unit event detection.
   ////////////////////////////////////////////////////////////////////////////
   // Two stages for metastability, a third for edge history.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end
      else
      begin
         sync1_reg <= chan_pin_i;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // Match events of every unit, capture events of the ten channels, plus timer clear and converter requests.
   always_comb
   begin
      eac_ctrl_t     c;
      logic [TW-1:0] ref_t;
      logic          rise;
      logic          fall;
      c      = '0;
      ref_t  = '0;
      rise   = 1'b0;
      fall   = 1'b0;
      cmp_ev = '0;
      cap_ev = '0;
      eq_now = '0;
      t1_clr = 1'b0;
      t2_clr = 1'b0;
      adc_go = 1'b0;
      for (int u = 0; u < NU; u++)
      begin
         c     = eac_ctrl_t'(ctrl_reg[u]);
         ref_t = c.timebase_select ? timer2_i : timer1_i;
         // A match fires once when the equality begins, only while armed.
         eq_now[u] = c.compare_enable && (ref_t == time_reg[u]);
         cmp_ev[u] = eq_now[u] && !eq_prev_reg[u] && armed_reg[u];
         if (u < NCH)
         begin
            rise = sync2_reg[u] & ~sync3_reg[u];
            fall = ~sync2_reg[u] & sync3_reg[u];
            cap_ev[u] = !c.compare_enable &&
                        (((c.compare_action_select == 2'h1) && fall) ||
                         ((c.compare_action_select == 2'h2) && rise) ||
                         ((c.compare_action_select == 2'h3) && (rise || fall)));
         end
         // Clear target: timer 2 when reference xor opposite-select says so.
         if (cmp_ev[u] && c.timer_clear_enable)
         begin
            if (c.timebase_select ^ c.which_timer_clear_select)
               t2_clr = 1'b1;
            else
               t1_clr = 1'b1;
         end
         // In capture mode the opposite-select bit clears the opposite timer.
         if (cap_ev[u] && c.which_timer_clear_select)
         begin
            if (c.timebase_select)
               t1_clr = 1'b1;
            else
               t2_clr = 1'b1;
         end
         if (cmp_ev[u] && c.conversion_trigger)
            adc_go = 1'b1;
      end
   end

   assign ovr_ev = cap_ev[NCH-1:0] & full_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Control and event time registers.
   ////////////////////////////////////////////////////////////////////////////
   // Control bytes and the two pin sharing bits.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int u = 0; u < NU; u++)
            ctrl_reg[u] <= `EAC_RST_CTRL;
         share_reg <= 2'h0;
      end
      else
      begin
         for (int u = 0; u < NU; u++)
            if (wr_ctrl[u] && sel_i[0])
               ctrl_reg[u] <= dat_i[7:0];
         if (wr_ctrl[1] && sel_i[1])
            share_reg[0] <= dat_i[`EAC_F_RM];
         if (wr_ctrl[3] && sel_i[1])
            share_reg[1] <= dat_i[`EAC_F_RM];
      end
   end

   // Event times: software writes, captures store the reference timer.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int u = 0; u < NU; u++)
            time_reg[u] <= `EAC_RST_TIME;
         full_reg <= '0;
      end
      else
      begin
         for (int u = 0; u < NU; u++)
         begin
            if (wr_time[u])
               time_reg[u] <= merge16(time_reg[u], dat_i, sel_i);
            // Overrun keeps old data unless the overwrite bit is set.
            if (u < NCH)
               if (cap_ev[u] && (!full_reg[u] || ctrl_reg[u][0]))
                  time_reg[u] <= ctrl_reg[u][`EAC_F_TB] ? timer2_i : timer1_i;
         end
         // A capture sets the full flag and wins over a read that clears it.
         full_reg <= (full_reg & ~rd_time) | cap_ev[NCH-1:0];
      end
   end

   // One-shot arming: rewriting control or time re-arms the unit.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         armed_reg   <= '1;
         eq_prev_reg <= '0;
      end
      else
      begin
         eq_prev_reg <= eq_now;
         for (int u = 0; u < NU; u++)
         begin
            if (wr_ctrl[u] || wr_time[u])
               armed_reg[u] <= 1'b1;
            else if (cmp_ev[u] && !ctrl_reg[u][3])
               armed_reg[u] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output pins and trigger pulses.
   ////////////////////////////////////////////////////////////////////////////
   // Own compare action first; shared channel acts only when the owner is idle.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_reg     <= 10'h000;
         cmp_pin_reg <= 2'h0;
      end
      else
      begin
         for (int i = 0; i < NCH; i++)
            if (cmp_ev[i])
               pin_reg[i] <= pin_act(pin_reg[i], ctrl_reg[i][5:4]);
         if (share_reg[0] && cmp_ev[0] && !cmp_ev[1])
            pin_reg[1] <= pin_act(pin_reg[1], ctrl_reg[0][5:4]);
         if (share_reg[1] && cmp_ev[2] && !cmp_ev[3])
            pin_reg[3] <= pin_act(pin_reg[3], ctrl_reg[2][5:4]);
         for (int k = 0; k < 2; k++)
            if (cmp_ev[NCH + k])
               cmp_pin_reg[k] <= pin_act(cmp_pin_reg[k], ctrl_reg[NCH + k][5:4]);
      end
   end

   // Register trigger and channel event pulses so they leave from flip-flops.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trig_reg     <= '0;
         chan_irq_reg <= 4'h0;
      end
      else
      begin
         trig_reg.adc_start    <= adc_go;
         trig_reg.timer1_clear <= t1_clr;
         trig_reg.timer2_clear <= t2_clr;
         chan_irq_reg          <= cmp_ev[3:0] | cap_ev[3:0];
      end
   end

   assign chan_pin_o = pin_reg;
   assign cmp_pin_o  = cmp_pin_reg;
   assign trig_o     = trig_reg;
   assign chan_irq_o = chan_irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Multiplexed interrupt: flags, enables, priority vector.
   ////////////////////////////////////////////////////////////////////////////
   // Source layout: channels 4..9 at 19..14, overruns 0..9 at 13..4,
   // compare units at 3..2, timer overflows at 1..0.
   always_comb
   begin
      src = '0;
      for (int k = 0; k < 6; k++)
         src[19 - k] = cmp_ev[4 + k] | cap_ev[4 + k];
      for (int k = 0; k < NCH; k++)
         src[13 - k] = ovr_ev[k];
      src[3] = cmp_ev[10];
      src[2] = cmp_ev[11];
      src[1] = timer1_ovf_i;
      src[0] = timer2_ovf_i;
   end

   assign active = pend_reg & en_reg;

   // Highest flagged and enabled source; bit k reports code k plus one.
   always_comb
   begin
      vec_code = 5'h00;
      for (int k = 0; k < NS; k++)
         if (active[k])
            vec_code = 5'(k + 1);
   end

   // Flags cleared by a vector read or by the clear registers.
   always_comb
   begin
      clr = '0;
      if (rd && (adr_i == reg_addr(`EAC_IDX_PRIO_VEC)) && (vec_code != 5'h00))
         clr[vec_code - 5'h01] = 1'b1;
      if (wr && (adr_i == reg_addr(`EAC_IDX_CLR_MAIN)))
         clr[19:4] = merge16(16'h0000, dat_i, sel_i);
      if (wr && (adr_i == reg_addr(`EAC_IDX_CLR_EXTRA)) && sel_i[0])
         clr[3:0] = dat_i[3:0];
   end

   // Flags: a new event wins over a clear in the same cycle.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pend_reg <= '0;
      else
         pend_reg <= (pend_reg & ~clr) | src;
   end

   // Enable registers and the core level enable bit.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         en_reg      <= '0;
         core_en_reg <= 1'b0;
      end
      else
      begin
         if (wr && (adr_i == reg_addr(`EAC_IDX_EN_MAIN)))
            en_reg[19:4] <= merge16(en_reg[19:4], dat_i, sel_i);
         if (wr && (adr_i == reg_addr(`EAC_IDX_EN_EXTRA)) && sel_i[0])
            en_reg[3:0] <= dat_i[3:0];
         if (wr && (adr_i == reg_addr(`EAC_IDX_CORE_EN)) && sel_i[0])
            core_en_reg <= dat_i[0];
      end
   end

   // Level interrupt while any enabled flag stands and the core enable is set.
   assign irq_o = core_en_reg & (|active);
endmodule

// >>> verif/eac_top_properties.sv
// Concurrent checks on the ports of the event compare block.
`timescale 1ns/1ps
module eac_top_chk
   import eac_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       cyc_i,
   input wire logic       stb_i,
   input wire logic       ack_o,
   input wire logic       irq_o,
   input wire logic [1:0] cmp_pin_o,
   input wire logic [3:0] chan_irq_o,
   input wire eac_trig_t  trig_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // A request that the slave has not answered yet.
   sequence take_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   bus_answer_a: assert property (take_s |=> ack_o)
      else $error("request not answered in one cycle");
   ack_single_a: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   ack_cause_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without a request");
   rst_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !irq_o && cmp_pin_o == 2'h0)
      else $error("outputs active after reset");
   adc_pulse_a: assert property ($rose(trig_o.adc_start) |=> !trig_o.adc_start)
      else $error("converter start longer than one cycle");
   clr_one_a: assert property ($rose(trig_o.timer1_clear) |=> !trig_o.timer1_clear)
      else $error("timer 1 clear longer than one cycle");
   clr_two_a: assert property ($rose(trig_o.timer2_clear) |=> !trig_o.timer2_clear)
      else $error("timer 2 clear longer than one cycle");
   evt_pulse_a: assert property ((chan_irq_o & $past(chan_irq_o)) == 4'h0)
      else $error("channel event pulse longer than one cycle");
endmodule
bind eac_top eac_top_chk eac_top_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .ack_o(ack_o), .irq_o(irq_o), .cmp_pin_o(cmp_pin_o),
   .chan_irq_o(chan_irq_o), .trig_o(trig_o));

// >>> verif/eac_top_test.sv
// Self-checking bench of the event compare block.
`timescale 1ns/1ps
`include "eac_map.svh"
module eac_top_test;
   import eac_pkg::*;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, ovf1, ovf2;
   logic [15:0] adr_i, t1, t2, rnd;
   logic [3:0]  sel_i, chan_irq_o;
   logic [31:0] dat_i, dat_o;
   logic [9:0]  chan_pin_i, chan_pin_o;
   logic [1:0]  cmp_pin_o;
   eac_trig_t   trig_o;
   int          err_total, checked, cyc_n;
   logic [31:0] exp_q[$];
   logic [1:0]  acts[4] = '{2'h1, 2'h2, 2'h0, 2'h3};
   logic        pins[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   eac_top eac_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .timer1_i(t1), .timer2_i(t2), .timer1_ovf_i(ovf1), .timer2_ovf_i(ovf2),
      .chan_pin_i(chan_pin_i), .chan_pin_o(chan_pin_o), .cmp_pin_o(cmp_pin_o),
      .chan_irq_o(chan_irq_o), .trig_o(trig_o), .irq_o(irq_o));
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Prints the verdict and ends the run.
   task complete_run;
      if (err_total == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Compares one value and counts a mismatch.
   task chk(input string n, input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, want, seen);
      end
   endtask
   // Xorshift source of the random event time.
   function automatic logic [15:0] xs(input logic [15:0] v);
      logic [15:0] x;
      x = v ^ (v << 7);
      x = x ^ (x >> 9);
      return x ^ (x << 8);
   endfunction
   // One classic single cycle; held until ack is sampled high.
   task bus(input logic [15:0] idx, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {idx[13:0], 2'b00};
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1)
         @(posedge clk_i);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task rd(input logic [15:0] idx, input logic [31:0] want);
      exp_q.push_back(want);
      bus(idx, 1'b0, 32'h0);
   endtask
   // Read data is compared against the oldest note; a hang is cut short.
   always @(posedge clk_i)
   begin
      cyc_n++;
      if (ack_o === 1'b1 && we_i === 1'b0)
         chk("read data", dat_o, exp_q.pop_front());
      if (cyc_n == 4000)
      begin
         err_total++;
         complete_run();
      end
   end
   // Puts timer 1 (u low) or timer 2 (u high) on the event time for one cycle.
   // Pin and trigger pulses change at the same edge; the pulses last one cycle.
   task hit(input logic u, input logic want, input logic [2:0] trg);
      if (u)
         t2 <= rnd;
      else
         t1 <= rnd;
      @(posedge clk_i);
      t1 <= rnd + 16'h0001;
      t2 <= 16'h1234;
      #1;
      chk("compare pin", 32'(cmp_pin_o[u]), 32'(want));
      chk("trigger pulses", 32'(trig_o), 32'(trg));
      @(posedge clk_i);
      #1;
      chk("trigger pulses", 32'(trig_o), 32'h0);
      @(posedge clk_i);
   endtask
   // Main sequence: registers, compare actions, then the event interrupt.
   initial
   begin
      {rst_i, sel_i, t2, rnd} = {1'b1, 4'h3, 16'h1234, xs(16'h000B)};
      {cyc_i, stb_i, we_i, adr_i, dat_i, t1, ovf1, ovf2, chan_pin_i} = '0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`EAC_IDX_CMP0_CTRL, 32'h0);
      rd(`EAC_IDX_CH_CTRL + `EAC_IDX_CH_STRIDE, 32'hFE00);
      rd(16'h0100, 32'h0);
      bus(`EAC_IDX_CMP0_TIME, 1'b1, {16'h0, rnd});
      rd(`EAC_IDX_CMP0_TIME, {16'h0, rnd});
      bus(`EAC_IDX_CMP0_CTRL, 1'b1, 32'h65);
      hit(1'b0, 1'b1, 3'h6);
      foreach (acts[i])
      begin
         bus(`EAC_IDX_CMP0_CTRL, 1'b1, {24'h0, 2'b01, acts[i], 4'h0});
         hit(1'b0, pins[i], 3'h0);
      end
      hit(1'b0, 1'b0, 3'h0);
      bus(`EAC_IDX_CMP0_CTRL, 1'b1, 32'h20);
      hit(1'b0, 1'b0, 3'h0);
      bus(`EAC_IDX_EN_EXTRA, 1'b1, 32'h8);
      bus(`EAC_IDX_CORE_EN, 1'b1, 32'h1);
      chk("irq", 32'(irq_o), 32'h1);
      bus(`EAC_IDX_CORE_EN, 1'b1, 32'h0);
      chk("irq", 32'(irq_o), 32'h0);
      bus(`EAC_IDX_CORE_EN, 1'b1, 32'h1);
      {ovf1, ovf2} <= 2'h3;
      @(posedge clk_i);
      {ovf1, ovf2} <= 2'h0;
      bus(`EAC_IDX_EN_EXTRA, 1'b1, 32'hB);
      rd(`EAC_IDX_PRIO_VEC, 32'h4);
      rd(`EAC_IDX_PRIO_VEC, 32'h2);
      rd(`EAC_IDX_PEND_EXTRA, 32'h1);
      bus(`EAC_IDX_EN_EXTRA, 1'b1, 32'h8);
      chk("irq", 32'(irq_o), 32'h0);
      bus(`EAC_IDX_CLR_EXTRA, 1'b1, 32'hF);
      rd(`EAC_IDX_PEND_EXTRA, 32'h0);
      // Compare unit 1 runs on timer 2 and clears the opposite timer.
      bus(`EAC_IDX_CMP1_TIME, 1'b1, {16'h0, rnd});
      bus(`EAC_IDX_CMP1_CTRL, 1'b1, 32'hE3);
      hit(1'b1, 1'b1, 3'h2);
      rd(`EAC_IDX_PEND_EXTRA, 32'h4);
      // Channel 0 sets its own pin and, shared, the pin of channel 1.
      bus(`EAC_IDX_CH_TIME, 1'b1, {16'h0, rnd});
      bus(`EAC_IDX_CH_CTRL + `EAC_IDX_CH_STRIDE, 1'b1, 32'h100);
      bus(`EAC_IDX_CH_CTRL, 1'b1, 32'h60);
      hit(1'b0, 1'b0, 3'h0);
      chk("channel pins", 32'(chan_pin_o), 32'h3);
      // Rising edges on channels 2 and 4 capture timer 1 after the synchroniser.
      bus(`EAC_IDX_CH_CTRL + 16'h0008, 1'b1, 32'h20);
      bus(`EAC_IDX_CH_CTRL + 16'h0010, 1'b1, 32'h20);
      chan_pin_i <= 10'h014;
      repeat (3) @(posedge clk_i);
      #1;
      chk("channel pulses", 32'(chan_irq_o), 32'h4);
      rd(`EAC_IDX_CH_TIME + 16'h0010, {16'h0, rnd + 16'h0001});
      rd(`EAC_IDX_PEND_MAIN, 32'h8000);
      repeat (3) @(posedge clk_i);
      complete_run();
   end
endmodule
